/* design/dsq_global_regs.sv */
// dsq_global_regs: global sequencer control, unit status, mask and timers
// assumes a strobe register port on core_clk and async settle pins
//
// Overview of operation
// (RULE1) control bit 8 gates every interrupt; zero suppresses them all
// (RULE2) control bits 0..7 start (1) or stop (0) unit 1..8 sequencer
// (RULE3) activity flag stays set throughout a running sequencer
// (RULE4) on stop the transfer finishes; activity clears only once halted
// (RULE5) sequencers started by one write begin in the same cycle
// (RULE6) software programs timer, timed mode, then first data before start
// (RULE7) status packs underflow, request, settling, activity per unit nibble
// (RULE8) control bits 31..9 reserved; write zero, read value undefined
// (RULE9) underflow set when fetch finds request unacknowledged; sequencer goes on
// (RULE10) update interval equals (preload plus one) times ten microseconds
// (RULE11) writing zero keeps clearable flags; read-only flags ignore writes
`timescale 1ns/100ps
module dsq_global_regs
  import dsq_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdData,
  // unit pins
  input  wire logic [NUM_UNITS-1:0] unitSettle,
  output logic      [NUM_UNITS-1:0] unitFetch,
  output logic      [NUM_UNITS-1:0] unitUpdate,
  output logic      [NUM_UNITS-1:0] unitXfer,
  // interrupt
  output logic                      irq
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [CTRL_W-1:0]    ctrl, next_ctrl;
  logic [31:0]          mask, next_mask;
  logic [PRELOAD_W-1:0] preload [NUM_UNITS];
  logic [PRELOAD_W-1:0] next_preload [NUM_UNITS];
  logic [NUM_UNITS-1:0] uflow, next_uflow;
  logic [NUM_UNITS-1:0] req, next_req;
  logic [NUM_UNITS-1:0] settleMeta, settleSync;
  logic [NUM_UNITS-1:0] unitActive;
  logic [6:0]           tickCnt, next_tickCnt;
  logic                 tick;
  logic [31:0]          statWord;
  logic [31:0]          next_rdData;
  logic                 next_irq;
  logic                 wrCtrl, wrStat, wrMask, wrTmr;
  logic [2:0]           tmrIdx;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // timers sit on aligned words 0x60..0x7c, one per unit
  always_comb
  begin
    wrCtrl = 1'b0;
    wrStat = 1'b0;
    wrMask = 1'b0;
    wrTmr  = 1'b0;
    tmrIdx = regAddr[4:2];
    if (regWr && regAddr == OFS_CTRL)
      wrCtrl = 1'b1;
    else if (regWr && regAddr == OFS_STAT)
      wrStat = 1'b1;
    else if (regWr && regAddr == OFS_MASK)
      wrMask = 1'b1;
    else if (regWr && regAddr >= OFS_TMR_LO && regAddr <= OFS_TMR_HI && regAddr[1:0] == 2'b00)
      wrTmr = 1'b1;
  end

  // ----------------------------------------
  // 10 us timebase
  // ----------------------------------------
  // one shared divider keeps all units in phase with each other
  always_comb
  begin
    tick         = (tickCnt == '0);
    next_tickCnt = tick ? TICK_LAST : tickCnt - 7'h01;
  end

  // ----------------------------------------
  // control, mask and timer writes
  // ----------------------------------------
  always_comb
  begin
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_preload = preload;
    // (RULE2) start/stop and gate bits
    if (wrCtrl)
      next_ctrl = regWrData[CTRL_W-1:0];
    if (wrMask)
      next_mask = regWrData;
    if (wrTmr)
      next_preload[tmrIdx] = regWrData[PRELOAD_W-1:0];
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl    <= CTRL_RST;
      mask    <= MASK_RST;
      tickCnt <= TICK_LAST;
      for (int i = 0; i < NUM_UNITS; i++)
        preload[i] <= PRELOAD_RST;
    end
    else
    begin
      ctrl    <= next_ctrl;
      mask    <= next_mask;
      tickCnt <= next_tickCnt;
      preload <= next_preload;
    end
  end

  // ----------------------------------------
  // settle pin synchroniser
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      settleMeta <= FLAGS_RST;
      settleSync <= FLAGS_RST;
    end
    else
    begin
      settleMeta <= unitSettle;
      settleSync <= settleMeta;
    end
  end

  // ----------------------------------------
  // unit sequencers
  // ----------------------------------------
  // (RULE5) one write reaches all run inputs at once
  generate
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_unit
      dsq_unit_seq u_seq (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tick     (tick),
        .runReq   (ctrl[u]),
        .preload  (preload[u]),
        .active   (unitActive[u]),
        .fetch    (unitFetch[u]),
        .update   (unitUpdate[u]),
        .xferBusy (unitXfer[u])
      );
    end
  endgenerate

  // ----------------------------------------
  // clearable status flags
  // ----------------------------------------
  // a fetch in the clearing cycle wins, so no event is lost
  always_comb
  begin
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      // (RULE11) only written ones clear
      next_uflow[i] = uflow[i] & ~(wrStat & regWrData[4*i+STAT_UFLOW]);
      next_req[i]   = req[i] & ~(wrStat & regWrData[4*i+STAT_REQ]);
      // (RULE9) unacknowledged data flags underflow
      if (unitFetch[i] && req[i])
        next_uflow[i] = 1'b1;
      if (unitFetch[i])
        next_req[i] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      uflow <= FLAGS_RST;
      req   <= FLAGS_RST;
    end
    else
    begin
      uflow <= next_uflow;
      req   <= next_req;
    end
  end

  // ----------------------------------------
  // status word and read mux
  // ----------------------------------------
  // (RULE7) four flags per unit nibble
  always_comb
  begin
    statWord = 32'h0000_0000;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      statWord[4*i+STAT_UFLOW]  = uflow[i];
      statWord[4*i+STAT_REQ]    = req[i];
      statWord[4*i+STAT_SETTLE] = settleSync[i];
      // (RULE3) activity follows the sequencer
      statWord[4*i+STAT_ACT]    = unitActive[i];
    end
  end

  // unmapped and reserved bits read zero so software sees a stable value
  always_comb
  begin
    next_rdData = 32'h0000_0000;
    if (!regRd)
      next_rdData = 32'h0000_0000;
    // (RULE8) reserved bits read zero
    else if (regAddr == OFS_CTRL)
      next_rdData = {23'h00_0000, ctrl};
    else if (regAddr == OFS_STAT)
      next_rdData = statWord;
    else if (regAddr == OFS_MASK)
      next_rdData = mask;
    else if (regAddr >= OFS_TMR_LO && regAddr <= OFS_TMR_HI && regAddr[1:0] == 2'b00)
      next_rdData = {8'h00, preload[tmrIdx]};
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // only clearable flags raise; level flags would hold the line forever
  always_comb
  begin
    next_irq = 1'b0;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      if (uflow[i] && mask[4*i+STAT_UFLOW])
        next_irq = 1'b1;
      if (req[i] && mask[4*i+STAT_REQ])
        next_irq = 1'b1;
    end
    // (RULE1) master gate over all sources
    if (!ctrl[CTRL_GATE_BIT])
      next_irq = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regRdData <= 32'h0000_0000;
      irq       <= 1'b0;
    end
    else
    begin
      regRdData <= next_rdData;
      irq       <= next_irq;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_gate_off;
    @(posedge core_clk) disable iff (!rst_b)
    !ctrl[CTRL_GATE_BIT] |=> !irq;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("irq high with gate off"); // RULE1

  property p_gate_on;
    @(posedge core_clk) disable iff (!rst_b)
    (ctrl[CTRL_GATE_BIT] && (uflow[0] & mask[STAT_UFLOW])) |=> irq;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("irq missing"); // RULE1

  property p_ctrl_write;
    @(posedge core_clk) disable iff (!rst_b)
    wrCtrl |=> ctrl[7:0] == $past(regWrData[7:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("run bits not stored"); // RULE2

  property p_run_active;
    @(posedge core_clk) disable iff (!rst_b)
    (ctrl[0] && unitActive[0]) ##1 ctrl[0] |-> unitActive[0];
  endproperty
  a_run_active: assert property (p_run_active) else $error("activity dropped while running"); // RULE3

  property p_start_together;
    @(posedge core_clk) disable iff (!rst_b)
    (wrCtrl && ctrl[7:0] == 8'h00 && unitActive == 8'h00) |=> ##1 unitActive == $past(ctrl[7:0]);
  endproperty
  a_start_together: assert property (p_start_together) else $error("units did not start together"); // RULE5

  property p_stat_layout;
    @(posedge core_clk) disable iff (!rst_b)
    (regRd && regAddr == OFS_STAT)
      |=> regRdData[31:28] == {$past(uflow[7]), $past(req[7]), $past(settleSync[7]), $past(unitActive[7])};
  endproperty
  a_stat_layout: assert property (p_stat_layout) else $error("status nibble misplaced"); // RULE7

  property p_ctrl_reserved;
    @(posedge core_clk) disable iff (!rst_b)
    (regRd && regAddr == OFS_CTRL) |=> regRdData[31:9] == 23'h00_0000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits nonzero"); // RULE8

  property p_underflow;
    @(posedge core_clk) disable iff (!rst_b)
    (unitFetch[0] && req[0]) |=> uflow[0] && req[0];
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not flagged"); // RULE9

  property p_zero_keeps;
    @(posedge core_clk) disable iff (!rst_b)
    (wrStat && !regWrData[STAT_UFLOW] && uflow[0]) |=> uflow[0];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag cleared by zero write"); // RULE11

  property p_one_clears;
    @(posedge core_clk) disable iff (!rst_b)
    (wrStat && regWrData[STAT_REQ] && !unitFetch[0]) |=> !req[0];
  endproperty
  a_one_clears: assert property (p_one_clears) else $error("flag not cleared by one"); // RULE11

  property p_gate_on_req;
    @(posedge core_clk) disable iff (!rst_b)
    (ctrl[CTRL_GATE_BIT] && req[0] && mask[STAT_REQ]) |=> irq;
  endproperty
  a_gate_on_req: assert property (p_gate_on_req) else $error("irq missing for request"); // RULE1

  property p_mask_off;
    @(posedge core_clk) disable iff (!rst_b)
    (mask == 32'h0000_0000) |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq high with every source masked"); // RULE1

  property p_underflow_all;
    @(posedge core_clk) disable iff (!rst_b)
    ((unitFetch & req) != '0) |=> (uflow & $past(unitFetch) & $past(req)) == ($past(unitFetch) & $past(req));
  endproperty
  a_underflow_all: assert property (p_underflow_all) else $error("underflow missed on a unit"); // RULE9

  // bound covers a stop landing on a fresh 16-cycle transfer plus the halt step
  property p_halt_ends;
    @(posedge core_clk) disable iff (!rst_b)
    (!ctrl[0] && unitActive[0]) |-> ##[1:20] !unitActive[0];
  endproperty
  a_halt_ends: assert property (p_halt_ends) else $error("stopped unit never halted"); // RULE4
endmodule // dsq_global_regs

/* pkg/dsq_pkg.sv */
// dsq_pkg: constants and types for the sequencer global control/status bank
// assumes a single 10 MHz core clock shared by every file of the block
package dsq_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int          NUM_UNITS   = 8;
  localparam int          PRELOAD_W   = 24;
  localparam int          XFER_W      = 5;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL    = 8'h88;
  localparam logic [7:0]  OFS_STAT    = 8'h8c;
  localparam logic [7:0]  OFS_MASK    = 8'h90;
  localparam logic [7:0]  OFS_TMR_LO  = 8'h60;
  localparam logic [7:0]  OFS_TMR_HI  = 8'h7c;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int          CTRL_GATE_BIT = 8;
  localparam int          CTRL_W        = 9;
  localparam int          STAT_ACT      = 0;
  localparam int          STAT_SETTLE   = 1;
  localparam int          STAT_REQ      = 2;
  localparam int          STAT_UFLOW    = 3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [8:0]  CTRL_RST    = 9'h000;
  localparam logic [31:0] MASK_RST    = 32'h0000_0000;
  localparam logic [23:0] PRELOAD_RST = 24'h00_0000;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_NS      = 100;
  localparam int          TICK_US     = 10;
  localparam int          TICK_CYC    = (TICK_US * 1000) / CLK_NS;
  localparam logic [6:0]  TICK_LAST   = 7'(TICK_CYC - 1);
  localparam logic [4:0]  XFER_CYC    = 5'h10;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSQ_IDLE = 2'b00,
    DSQ_RUN  = 2'b01,
    DSQ_HALT = 2'b10
  } dsq_seq_state_t;
endpackage

/* design/dsq_unit_seq.sv */
// dsq_unit_seq: timed-update sequencer of one converter unit
// assumes tick is a one-cycle pulse every 10 us on the core clock
`timescale 1ns/100ps
module dsq_unit_seq
  import dsq_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // control
  input  wire logic                 tick,
  input  wire logic                 runReq,
  input  wire logic [PRELOAD_W-1:0] preload,
  // status
  output logic                      active,
  output logic                      fetch,
  output logic                      update,
  output logic                      xferBusy
);
  dsq_seq_state_t       state, next_state;
  logic [PRELOAD_W-1:0] cnt, next_cnt;
  logic [XFER_W-1:0]    xferCnt, next_xferCnt;
  logic                 next_fetch, next_update;
  logic                 next_active, next_xferBusy;

  // sequencing: counter reloads on expiry so the period is exact
  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_xferCnt = (xferCnt != '0) ? xferCnt - 5'h01 : xferCnt;
    next_fetch   = 1'b0;
    next_update  = 1'b0;
    case (state)
      DSQ_IDLE:
      begin
        if (runReq)
        begin
          next_state   = DSQ_RUN;
          next_cnt     = preload;
          next_fetch   = 1'b1;
          next_xferCnt = XFER_CYC;
        end
      end
      DSQ_RUN:
      begin
        // (RULE4) stop defers to transfer
        if (!runReq)
          next_state = DSQ_HALT;
        else if (tick)
        begin
          // (RULE10) update every preload+1 ticks
          if (cnt == '0)
          begin
            next_update  = 1'b1;
            next_cnt     = preload;
            next_fetch   = 1'b1;
            next_xferCnt = XFER_CYC;
          end
          else
            next_cnt = cnt - 24'h00_0001;
        end
      end
      DSQ_HALT:
      begin
        if (xferCnt == '0)
          next_state = DSQ_IDLE;
      end
      default: next_state = DSQ_IDLE;
    endcase
    // activity covers running and halting alike, so software sees the real stop
    next_active   = (next_state != DSQ_IDLE);
    next_xferBusy = (next_xferCnt != '0);
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= DSQ_IDLE;
      cnt      <= PRELOAD_RST;
      xferCnt  <= '0;
      fetch    <= 1'b0;
      update   <= 1'b0;
      active   <= 1'b0;
      xferBusy <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      xferCnt  <= next_xferCnt;
      fetch    <= next_fetch;
      update   <= next_update;
      active   <= next_active;
      xferBusy <= next_xferBusy;
    end
  end

  property p_halt_waits;
    @(posedge core_clk) disable iff (!rst_b)
    (state == DSQ_HALT && xferCnt != '0) |=> active;
  endproperty
  a_halt_waits: assert property (p_halt_waits) else $error("active dropped mid transfer"); // RULE4

  property p_update_on_expiry;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(update) |-> $past(tick) && $past(cnt) == '0 && cnt == $past(preload);
  endproperty
  a_update_on_expiry: assert property (p_update_on_expiry) else $error("update off interval"); // RULE10
endmodule // dsq_unit_seq

/* sim/dsq_global_regs_tb.sv */
// dsq_global_regs_tb: register-level bench for the global sequencer control/status bank
// assumes dsq_pkg is compiled first; the bench drives every input port of the bank itself
`timescale 1ns/100ps
module dsq_global_regs_tb
  import dsq_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                 core_clk;
  logic                 rst_b;
  logic [7:0]           regAddr;
  logic [31:0]          regWrData;
  logic                 regWr;
  logic                 regRd;
  logic [31:0]          regRdData;
  logic [NUM_UNITS-1:0] unitSettle;
  logic [NUM_UNITS-1:0] unitFetch;
  logic [NUM_UNITS-1:0] unitUpdate;
  logic [NUM_UNITS-1:0] unitXfer;
  logic                 irq;
  int                   nFail;
  int                   testsRun;
  int                   cyc;
  int                   hits;

  dsq_global_regs i_dut (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .regAddr    (regAddr),
    .regWrData  (regWrData),
    .regWr      (regWr),
    .regRd      (regRd),
    .regRdData  (regRdData),
    .unitSettle (unitSettle),
    .unitFetch  (unitFetch),
    .unitUpdate (unitUpdate),
    .unitXfer   (unitXfer),
    .irq        (irq)
  );

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk32(input string name, input logic [31:0] expv, input logic [31:0] got);
    testsRun++;
    if (got !== expv)
    begin
      $display("Error %s expected %h seen %h", name, expv, got);
      nFail++;
    end
  endtask

  task automatic chk1(input string name, input logic expv, input logic got);
    testsRun++;
    if (got !== expv)
    begin
      $display("Error %s expected %b seen %b", name, expv, got);
      nFail++;
    end
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr     <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so sample it just past that edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] expv, input logic [31:0] msk,
                        input string name);
    logic [31:0] d;
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1;
    d = regRdData & msk;
    chk32(name, expv, d);
  endtask

  // kind 0 waits for a fetch, 1 for an update, 2 for the end of a transfer
  task automatic wait_on(input int kind, input int u, output int n);
    logic hit;
    n   = 0;
    hit = 1'b0;
    while (!hit && n < 1000)
    begin
      @(posedge core_clk);
      #1;
      n++;
      case (kind)
        0:       hit = (unitFetch[u] === 1'b1);
        1:       hit = (unitUpdate[u] === 1'b1);
        default: hit = (unitXfer[u] === 1'b0);
      endcase
    end
    chk1("unit event seen", 1'b1, hit);
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    $display("Error watchdog expected done seen timeout");
    nFail++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    core_clk   = 1'b0;
    rst_b      = 1'b0;
    regAddr    = 8'h00;
    regWrData  = 32'h0000_0000;
    regWr      = 1'b0;
    regRd      = 1'b0;
    unitSettle = 8'h00;
    nFail      = 0;
    testsRun   = 0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values and an unmapped place
    rd_chk(OFS_CTRL, 32'h0000_0000, 32'h0000_01ff, "ctrl reset");
    rd_chk(OFS_STAT, 32'h0000_0000, 32'hffff_ffff, "status reset");
    rd_chk(8'hfc, 32'h0000_0000, 32'hffff_ffff, "unmapped read");
    // timers first, then start; preload 1 keeps the interval short
    wr(OFS_TMR_LO, 32'h0000_0001);
    wr(8'h68, 32'h0000_0001);
    rd_chk(8'h68, 32'h0000_0001, 32'hffff_ffff, "preload unit3");
    wr(OFS_MASK, 32'h0000_0004);
    @(posedge core_clk);
    // units 7 and 8 settling, so the top nibble is exercised too
    unitSettle <= 8'hc0;
    // units 1 and 3 started by one write must fetch in the same cycle
    wr(OFS_CTRL, 32'h0000_0005);
    wait_on(0, 0, cyc);
    chk32("start delay", 32'd1, 32'(cyc));
    chk32("joint fetch", 32'h0000_0005, {24'h0, unitFetch});
    rd_chk(OFS_STAT, 32'h2200_0505, 32'hffff_ffff, "status running");
    // second fetch with request still set raises underflow, sequencer goes on
    wait_on(1, 0, cyc);
    wait_on(1, 0, cyc);
    chk32("update gap", 32'(2 * TICK_CYC), 32'(cyc));
    rd_chk(OFS_STAT, 32'h2200_0d0d, 32'hffff_ffff, "underflow");
    chk1("irq gate off", 1'b0, irq);
    // zeros and read-only bits are ignored, ones clear
    wr(OFS_STAT, 32'h0000_0000);
    wr(OFS_STAT, 32'h2200_0101);
    rd_chk(OFS_STAT, 32'h2200_0d0d, 32'hffff_ffff, "status kept");
    wr(OFS_STAT, 32'h0000_000c);
    rd_chk(OFS_STAT, 32'h2200_0d01, 32'hffff_ffff, "unit1 cleared");
    // gate on: only the masked-in request of unit1 may raise irq
    wr(OFS_CTRL, 32'h0000_0105);
    repeat (3) @(posedge core_clk);
    #1;
    chk1("irq none unmasked", 1'b0, irq);
    wait_on(0, 0, cyc);
    repeat (3) @(posedge core_clk);
    #1;
    chk1("irq raised", 1'b1, irq);
    wr(OFS_MASK, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    #1;
    chk1("irq masked", 1'b0, irq);
    // stop unit1 in mid transfer: activity holds until the transfer ends
    wait_on(0, 0, cyc);
    wr(OFS_CTRL, 32'h0000_0004);
    #1;
    chk1("transfer runs on", 1'b1, unitXfer[0]);
    rd_chk(OFS_STAT, 32'h0000_0101, 32'h0000_0101, "active halting");
    wait_on(2, 0, cyc);
    repeat (2) @(posedge core_clk);
    rd_chk(OFS_STAT, 32'h0000_0100, 32'h0000_0101, "halted");
    rd_chk(OFS_CTRL, 32'h0000_0004, 32'h0000_01ff, "ctrl readback");
    // a halted unit makes no further updates
    hits = 0;
    repeat (300)
    begin
      @(posedge core_clk);
      #1;
      if (unitUpdate[0] === 1'b1)
        hits++;
    end
    chk32("updates after stop", 32'd0, 32'(hits));
    close_out();
  end
endmodule // dsq_global_regs_tb
